// file: acs_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// register shadow and assertions
// ----------------------------------------
module acs_chk (
   // clock and reset
   input wire MCLK,
   input wire RST_N,
   // write channels
   input wire [3:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire [1:0] S_AXI_BRESP,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // acquisition side
   input wire FRAME_DONE,
   input wire [3:0] TABLE_OUT,
   input wire GEN_CLK,
   input wire AUX_SIG,
   input wire TG_ENC,
   input wire TG_TRIG,
   input wire ENC_PIN,
   input wire ACQ_FROZEN,
   input wire GEN_SYNC_MODE,
   input wire ENC_TO_CIRCUIT,
   input wire TRIG_TO_CIRCUIT,
   input wire [3:0] GEN_OUT
);
   reg [3:0] aw_r;
   reg [31:0] wd_r;
   reg [31:0] s0_r;
   reg [11:0] s1_r;
   reg [7:0] s2_r;
   reg [19:0] fcnt_r;
   wire [3:0] exp_v;
   wire [3:0] msk;
   wire bh = S_AXI_BVALID && S_AXI_BREADY && S_AXI_BRESP == 2'h0;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   // shadows move at the response handshake, so checks skip bvalid cycles
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_r <= 4'h0;
         wd_r <= 32'h0;
         s0_r <= 32'h0;
         s1_r <= 12'h0;
         s2_r <= 8'h0;
         fcnt_r <= 20'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
            aw_r <= S_AXI_AWADDR;
         if (S_AXI_WVALID && S_AXI_WREADY)
            wd_r <= S_AXI_WDATA;
         if (bh && aw_r == 4'h0)
            s0_r <= wd_r;
         if (bh && aw_r == 4'h4)
            s1_r <= wd_r[11:0];
         if (bh && aw_r == 4'h8)
            s2_r <= wd_r[7:0];
         if (bh && (aw_r == 4'h0 || aw_r == 4'h8))
            fcnt_r <= 20'h0;
         else if (FRAME_DONE && s2_r[1:0] == 2'h1 && !ACQ_FROZEN)
            fcnt_r <= fcnt_r + 20'h1;
      end
   end

   // expected pins; code 7 on outputs 0 and 1 crosses synchronisers, left to bench
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_exp
         wire [2:0] c = s1_r[3*g +: 3];
         assign exp_v[g] = (c == 3'h0) ? s2_r[4+g] : (c == 3'h5) ? GEN_CLK :
            (c == 3'h6) ? AUX_SIG : (c == 3'h7) ? 1'b0 : TABLE_OUT[c[1:0] - 2'h1];
         assign msk[g] = (c != 3'h7) || (g > 1);
      end
   endgenerate

   sequence wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence enc_quiet;
      (!s0_r[30] && !S_AXI_BVALID && $stable(ENC_PIN))[*8];
   endsequence

   // the response is registered one edge after both halves are held
   wr_resp_a: assert property (wr_take |=> ##1 S_AXI_BVALID && !S_AXI_AWREADY &&
      S_AXI_BRESP == ((aw_r == 4'hc || aw_r[1:0] != 2'h0) ? 2'h2 : 2'h0))
      else $error("bad write answer");
   sync_mode_a: assert property (bh && aw_r == 4'h0 |=> GEN_SYNC_MODE == wd_r[22])
      else $error("sync mode wrong");
   enc_gen_a: assert property (s0_r[30] && !S_AXI_BVALID |=> ENC_TO_CIRCUIT == $past(TG_ENC))
      else $error("encoder not from generator");
   trig_gen_a: assert property (s0_r[31] && !S_AXI_BVALID |=> TRIG_TO_CIRCUIT == $past(TG_TRIG))
      else $error("trigger not from generator");
   enc_pin_a: assert property (enc_quiet |-> ENC_TO_CIRCUIT == ENC_PIN)
      else $error("encoder not from pin");
   out_mux_a: assert property (!S_AXI_BVALID |=>
      ((GEN_OUT ^ $past(exp_v)) & $past(msk)) == 4'h0) else $error("output source wrong");
   frz_code_a: assert property (s2_r[1:0] != 2'h1 && !S_AXI_BVALID |=> !ACQ_FROZEN)
      else $error("frozen under other code");
   frz_rise_a: assert property ($rose(ACQ_FROZEN) |-> fcnt_r == s0_r[19:0])
      else $error("froze at wrong count");
   frz_early_a: assert property (s2_r[1:0] == 2'h1 && fcnt_r != s0_r[19:0] &&
      !S_AXI_BVALID |-> !ACQ_FROZEN) else $error("frozen before count");
endmodule

bind acs_top acs_chk i_chk (.*);

// file: acs_consts.vh
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACS_OFF_ACQ_CTRL 4'h0
`define ACS_OFF_ROUTE_CTRL 4'h4
`define ACS_OFF_AUX_CTRL 4'h8
`define ACS_OFF_ACQ_STAT 4'hc

// ----------------------------------------------------------------
// acq_count_and_source_ctrl fields
// ----------------------------------------------------------------
`define ACS_STOP_CNT_HI 19
`define ACS_STOP_CNT_LO 0
`define ACS_SPARE_HI 21
`define ACS_SPARE_LO 20
`define ACS_SYNC_BIT 22
`define ACS_BANK_HI 29
`define ACS_BANK_LO 24
`define ACS_TG_ENC_BIT 30
`define ACS_TG_TRIG_BIT 31
`define ACS_ACQ_WR_MASK 32'hc07fffff

// ----------------------------------------------------------------
// output_routing_ctrl fields
// ----------------------------------------------------------------
`define ACS_SEL_W 3
`define ACS_ROUTE_W 12
`define ACS_SEL0_LO 0
`define ACS_SEL1_LO 3
`define ACS_SEL2_LO 6
`define ACS_SEL3_LO 9

// ----------------------------------------------------------------
// auxiliary control and status fields
// ----------------------------------------------------------------
`define ACS_FRZ_HI 1
`define ACS_FRZ_LO 0
`define ACS_HOST_HI 7
`define ACS_HOST_LO 4
`define ACS_FRZ_STOP_CODE 2'h1
`define ACS_STAT_FROZEN_BIT 31

// ----------------------------------------------------------------
// selector codes
// ----------------------------------------------------------------
`define ACS_CODE_HOST 3'h0
`define ACS_CODE_CT0 3'h1
`define ACS_CODE_CT1 3'h2
`define ACS_CODE_CT2 3'h3
`define ACS_CODE_CT3 3'h4
`define ACS_CODE_CLK 3'h5
`define ACS_CODE_AUX 3'h6
`define ACS_CODE_DIRECT 3'h7

// ----------------------------------------------------------------
// bus answers and reset values
// ----------------------------------------------------------------
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2
`define ACS_ZERO32 32'h00000000
`define ACS_CNT_ONE 20'h00001

`endif

// file: acs_outmux.v
`timescale 1ns/1ps
`include "acs_consts.vh"

// one connector output selector; code 7 source is per-instance
module acs_outmux #(
   parameter HAS_DIRECT = 1'b0
) (
   // selector and candidate sources
   input wire [2:0] sel,
   input wire host_bit,
   input wire [3:0] table_out,
   input wire gen_clk,
   input wire aux_sig,
   input wire direct_sig,
   // selected level
   output reg y
);

   // ----------------------------------------------------------------
   // source selection
   // ----------------------------------------------------------------
   // pure combinational; the top registers the result
   always @* begin
      case (sel)
         `ACS_CODE_HOST: y = host_bit;
         `ACS_CODE_CT0: y = table_out[0];
         `ACS_CODE_CT1: y = table_out[1];
         `ACS_CODE_CT2: y = table_out[2];
         `ACS_CODE_CT3: y = table_out[3];
         `ACS_CODE_CLK: y = gen_clk;
         `ACS_CODE_AUX: y = aux_sig;
         default: y = HAS_DIRECT ? direct_sig : 1'b0;
      endcase
   end

endmodule

// file: acs_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// far side: acquisition logic and connector
// ----------------------------------------
module acs_partner (
   // control from the bench
   input wire MCLK,
   input wire [7:0] src,
   input wire fire,
   input wire [1:0] pins,
   // levels into the block
   output logic FRAME_DONE,
   output wire [5:0] TAG_BANK,
   output wire [3:0] TABLE_OUT,
   output wire GEN_CLK,
   output wire AUX_SIG,
   output wire TG_ENC,
   output wire TG_TRIG,
   output wire ENC_PIN,
   output wire TRIG_PIN
);
   // sources held as levels so the one-cycle mux delay stays predictable
   assign {TG_TRIG, TG_ENC, AUX_SIG, GEN_CLK, TABLE_OUT} = src;
   assign TAG_BANK = src[7:2];
   assign {TRIG_PIN, ENC_PIN} = pins;
   initial FRAME_DONE = 1'b0;
   // one frame pulse every other cycle while fire is up
   always @(posedge MCLK) begin
      FRAME_DONE <= fire && !FRAME_DONE;
   end
endmodule

// file: acs_top.v
`timescale 1ns/1ps
`include "acs_consts.vh"

// Summary of operation
// - acquisition freezes once acquired frames equal the 20-bit stop count.
// - stop count only acts while freeze control code equals one.
// - bit 22 picks generator mode: zero free running, one encoder synced.
// - bits 29..24 read back the captured bank index, read-only.
// - bit 30 set makes timing generator drive the encoder circuit.
// - bit 31 set makes timing generator drive the trigger circuit.
// - outputs 0..2 have 3-bit selectors at bits 2..0, 5..3, 8..6.
// - output 3 selector sits at bits 11..9 with the same codes.
// - code 0 drives host output bit; codes 1..4 drive table outputs 0..3.
// - code 5 drives the internally generated clock.
// - code 6 drives the internally generated auxiliary signal.
// - code 7 on output 0 routes the encoder input.
// - code 7 on output 1 routes the trigger input.
module acs_top (
   // clock and reset
   input wire MCLK,
   input wire RST_N,
   // axi4-lite write address
   input wire [3:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   // axi4-lite write data
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   // axi4-lite write response
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // axi4-lite read address
   input wire [3:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   // axi4-lite read data
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // acquisition logic, same clock
   input wire FRAME_DONE,
   input wire [5:0] TAG_BANK,
   input wire [3:0] TABLE_OUT,
   input wire GEN_CLK,
   input wire AUX_SIG,
   input wire TG_ENC,
   input wire TG_TRIG,
   // connector pins, asynchronous
   input wire ENC_PIN,
   input wire TRIG_PIN,
   // acquisition side results
   output reg ACQ_FROZEN,
   output reg GEN_SYNC_MODE,
   output reg ENC_TO_CIRCUIT,
   output reg TRIG_TO_CIRCUIT,
   // connector outputs
   output reg [3:0] GEN_OUT
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   reg rst_s1_r;
   reg rst_s2_r;
   wire rst_n = rst_s2_r;
   reg [2:0] enc_sync_r;
   reg [2:0] trig_sync_r;
   reg enc_r;
   reg trig_r;
   reg [31:0] acq_ctrl_r;
   reg [11:0] route_r;
   reg [1:0] freeze_control_r;
   reg [3:0] host_out_r;
   reg [19:0] frame_cnt_r;
   reg [19:0] frame_cnt_nxt;
   reg frozen_nxt;
   reg [3:0] aw_addr_r;
   reg aw_held_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg w_held_r;
   reg [31:0] rdata_nxt;
   reg [1:0] rresp_nxt;
   wire do_write;
   wire aw_take;
   wire w_take;
   wire ar_take;
   wire [3:0] mux_y;
   wire [19:0] stop_count;
   wire stop_armed;
   wire restart;
   wire [31:0] route_merged = merge_be({20'h00000, route_r}, w_data_r, w_strb_r);

   // byte-lane merge of a write into an old word
   function [31:0] merge_be;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] be;
      integer i;
      begin
         merge_be = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge_be[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   // assert at once, release through two flops to avoid metastable exit
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // a pin level only counts once stages two and three agree,
   // which filters a single-cycle glitch at the cost of latency
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         enc_sync_r <= 3'h0;
         trig_sync_r <= 3'h0;
         enc_r <= 1'b0;
         trig_r <= 1'b0;
      end else begin
         enc_sync_r <= {enc_sync_r[1:0], ENC_PIN};
         trig_sync_r <= {trig_sync_r[1:0], TRIG_PIN};
         if (enc_sync_r[1] == enc_sync_r[2]) begin
            enc_r <= enc_sync_r[2];
         end
         if (trig_sync_r[1] == trig_sync_r[2]) begin
            trig_r <= trig_sync_r[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   // address and data are caught in either order; response follows both
   assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_take = S_AXI_WVALID && S_AXI_WREADY;
   assign do_write = aw_held_r && w_held_r && !S_AXI_BVALID;

   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_addr_r <= 4'h0;
         aw_held_r <= 1'b0;
         w_data_r <= `ACS_ZERO32;
         w_strb_r <= 4'h0;
         w_held_r <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `ACS_RESP_OKAY;
      end else begin
         // ready only while the holding slot is free
         S_AXI_AWREADY <= !aw_held_r && !aw_take;
         S_AXI_WREADY <= !w_held_r && !w_take;
         if (aw_take) begin
            aw_addr_r <= S_AXI_AWADDR;
            aw_held_r <= 1'b1;
         end
         if (w_take) begin
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB;
            w_held_r <= 1'b1;
         end
         if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            if (aw_addr_r == `ACS_OFF_ACQ_STAT || aw_addr_r[1:0] != 2'h0) begin
               S_AXI_BRESP <= `ACS_RESP_SLVERR;
            end else begin
               S_AXI_BRESP <= `ACS_RESP_OKAY;
            end
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // bank field is never stored here; it is read straight from the capture
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         acq_ctrl_r <= `ACS_ZERO32;
         route_r <= 12'h000;
         freeze_control_r <= 2'h0;
         host_out_r <= 4'h0;
      end else if (do_write) begin
         if (aw_addr_r == `ACS_OFF_ACQ_CTRL) begin
            acq_ctrl_r <= merge_be(acq_ctrl_r, w_data_r, w_strb_r) & `ACS_ACQ_WR_MASK;
         end else if (aw_addr_r == `ACS_OFF_ROUTE_CTRL) begin
            route_r <= route_merged[`ACS_ROUTE_W-1:0];
         end else if (aw_addr_r == `ACS_OFF_AUX_CTRL) begin
            if (w_strb_r[0]) begin
               freeze_control_r <= w_data_r[`ACS_FRZ_HI:`ACS_FRZ_LO];
               host_out_r <= w_data_r[`ACS_HOST_HI:`ACS_HOST_LO];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // frame stop counter
   // ----------------------------------------------------------------
   assign stop_count = acq_ctrl_r[`ACS_STOP_CNT_HI:`ACS_STOP_CNT_LO];
   assign stop_armed = (freeze_control_r == `ACS_FRZ_STOP_CODE);
   // a new count or mode restarts counting from zero
   assign restart = do_write && (aw_addr_r == `ACS_OFF_ACQ_CTRL ||
                                 aw_addr_r == `ACS_OFF_AUX_CTRL);

   always @* begin
      frame_cnt_nxt = frame_cnt_r;
      if (restart || !stop_armed) begin
         frame_cnt_nxt = 20'h00000;
      end else if (FRAME_DONE && !ACQ_FROZEN) begin
         frame_cnt_nxt = frame_cnt_r + `ACS_CNT_ONE;
      end
      frozen_nxt = stop_armed && !restart && (frame_cnt_nxt == stop_count);
   end

   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         frame_cnt_r <= 20'h00000;
         ACQ_FROZEN <= 1'b0;
      end else begin
         frame_cnt_r <= frame_cnt_nxt;
         ACQ_FROZEN <= frozen_nxt;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

   // read decode
   always @* begin
      rdata_nxt = `ACS_ZERO32;
      rresp_nxt = `ACS_RESP_OKAY;
      if (S_AXI_ARADDR[1:0] != 2'h0) begin
         rresp_nxt = `ACS_RESP_SLVERR;
      end else if (S_AXI_ARADDR == `ACS_OFF_ACQ_CTRL) begin
         rdata_nxt = acq_ctrl_r;
         rdata_nxt[`ACS_BANK_HI:`ACS_BANK_LO] = TAG_BANK;
      end else if (S_AXI_ARADDR == `ACS_OFF_ROUTE_CTRL) begin
         rdata_nxt[`ACS_ROUTE_W-1:0] = route_r;
      end else if (S_AXI_ARADDR == `ACS_OFF_AUX_CTRL) begin
         rdata_nxt[`ACS_FRZ_HI:`ACS_FRZ_LO] = freeze_control_r;
         rdata_nxt[`ACS_HOST_HI:`ACS_HOST_LO] = host_out_r;
      end else if (S_AXI_ARADDR == `ACS_OFF_ACQ_STAT) begin
         rdata_nxt[`ACS_STOP_CNT_HI:`ACS_STOP_CNT_LO] = frame_cnt_r;
         rdata_nxt[`ACS_STAT_FROZEN_BIT] = ACQ_FROZEN;
      end else begin
         rresp_nxt = `ACS_RESP_SLVERR;
      end
   end

   // one read at a time; arready drops until rdata is taken
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= `ACS_ZERO32;
         S_AXI_RRESP <= `ACS_RESP_OKAY;
      end else if (ar_take) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rdata_nxt;
         S_AXI_RRESP <= rresp_nxt;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end else if (!S_AXI_RVALID) begin
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // output selectors
   // ----------------------------------------------------------------
   // output 0 selector
   acs_outmux #(.HAS_DIRECT(1'b1)) u_mux0 (
      .sel(route_r[`ACS_SEL0_LO +: `ACS_SEL_W]),
      .host_bit(host_out_r[0]),
      .table_out(TABLE_OUT),
      .gen_clk(GEN_CLK),
      .aux_sig(AUX_SIG),
      .direct_sig(enc_r),
      .y(mux_y[0])
   );

   acs_outmux #(.HAS_DIRECT(1'b1)) u_mux1 (
      .sel(route_r[`ACS_SEL1_LO +: `ACS_SEL_W]),
      .host_bit(host_out_r[1]),
      .table_out(TABLE_OUT),
      .gen_clk(GEN_CLK),
      .aux_sig(AUX_SIG),
      .direct_sig(trig_r),
      .y(mux_y[1])
   );

   acs_outmux #(.HAS_DIRECT(1'b0)) u_mux2 (
      .sel(route_r[`ACS_SEL2_LO +: `ACS_SEL_W]),
      .host_bit(host_out_r[2]),
      .table_out(TABLE_OUT),
      .gen_clk(GEN_CLK),
      .aux_sig(AUX_SIG),
      .direct_sig(1'b0),
      .y(mux_y[2])
   );

   acs_outmux #(.HAS_DIRECT(1'b0)) u_mux3 (
      .sel(route_r[`ACS_SEL3_LO +: `ACS_SEL_W]),
      .host_bit(host_out_r[3]),
      .table_out(TABLE_OUT),
      .gen_clk(GEN_CLK),
      .aux_sig(AUX_SIG),
      .direct_sig(1'b0),
      .y(mux_y[3])
   );

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   // one flop on every output; a routed clock gains one cycle of delay
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         GEN_OUT <= 4'h0;
         GEN_SYNC_MODE <= 1'b0;
         ENC_TO_CIRCUIT <= 1'b0;
         TRIG_TO_CIRCUIT <= 1'b0;
      end else begin
         GEN_OUT <= mux_y;
         GEN_SYNC_MODE <= acq_ctrl_r[`ACS_SYNC_BIT];
         ENC_TO_CIRCUIT <= acq_ctrl_r[`ACS_TG_ENC_BIT] ? TG_ENC : enc_r;
         TRIG_TO_CIRCUIT <= acq_ctrl_r[`ACS_TG_TRIG_BIT] ? TG_TRIG : trig_r;
      end
   end

endmodule

// file: test_acq_count_and_output_steering.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench for the steering register bank
// ----------------------------------------
module test_acq_count_and_output_steering;
   logic MCLK = 0;
   logic RST_N = 0;
   logic [3:0] S_AXI_AWADDR = 0, S_AXI_WSTRB = 4'hf, S_AXI_ARADDR = 0;
   logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
   logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
   logic [31:0] S_AXI_WDATA = 0;
   logic [7:0] src = 8'hb4;
   logic fire = 0;
   logic [1:0] pins = 0;
   wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
   wire [31:0] S_AXI_RDATA;
   wire FRAME_DONE, GEN_CLK, AUX_SIG, TG_ENC, TG_TRIG, ENC_PIN, TRIG_PIN;
   wire [5:0] TAG_BANK;
   wire [3:0] TABLE_OUT, GEN_OUT;
   wire ACQ_FROZEN, GEN_SYNC_MODE, ENC_TO_CIRCUIT, TRIG_TO_CIRCUIT;
   int num_errors = 0;
   int total_checks = 0;

   acs_top i_acs_top (.*);
   acs_partner i_acs_partner (.*);

   // 40 MHz clock
   initial forever #12.5 MCLK = ~MCLK;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge MCLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1;
      S_AXI_WVALID <= 1;
      S_AXI_BREADY <= 1;
      while (!(aw && w)) begin
         @(posedge MCLK);
         if (!aw && S_AXI_AWREADY) begin
            aw = 1;
            S_AXI_AWVALID <= 0;
         end
         if (!w && S_AXI_WREADY) begin
            w = 1;
            S_AXI_WVALID <= 0;
         end
      end
      do @(posedge MCLK); while (S_AXI_BVALID !== 1'b1);
      chk("bresp", er, S_AXI_BRESP);
      S_AXI_BREADY <= 0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge MCLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1;
      S_AXI_RREADY <= 1;
      do @(posedge MCLK); while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 0;
      do @(posedge MCLK); while (S_AXI_RVALID !== 1'b1);
      chk("rresp", er, S_AXI_RRESP);
      chk("rdata", e, S_AXI_RDATA);
      S_AXI_RREADY <= 0;
   endtask

   // field layout, read-only bank index, refusals
   task automatic t_regs();
      rd(4'h0, 32'h2d000000, 2'h0);
      wr(4'h0, 32'hffffffff, 2'h0);
      rd(4'h0, 32'hed7fffff, 2'h0);
      wr(4'h0, 32'h3f312345, 2'h0);
      rd(4'h0, 32'h2d312345, 2'h0);
      wr(4'h4, 32'hfffff5a5, 2'h0);
      rd(4'h4, 32'h000005a5, 2'h0);
      wr(4'hc, 32'h00000001, 2'h2);
      rd(4'h2, 32'h00000000, 2'h2);
      wr(4'h0, 32'h0, 2'h0);
   endtask

   function automatic logic src_of(input logic [2:0] c, input int g, input logic [7:0] s,
                                   input logic [3:0] h, input logic [1:0] p);
      case (c)
         3'h0: return h[g];
         3'h5: return s[4];
         3'h6: return s[5];
         3'h7: return (g < 2) ? p[g] : 1'b0;
         default: return s[c - 3'h1];
      endcase
   endfunction

   // every code on every output, two source patterns each
   task automatic t_mux();
      logic [2:0] c;
      logic [7:0] s;
      logic [3:0] h, e;
      logic [1:0] p;
      for (int k = 0; k < 16; k++) begin
         c = k[2:0];
         s = k[3] ? 8'h5a : 8'ha5;
         h = k[3] ? 4'h9 : 4'h6;
         p = k[3] ? 2'b01 : 2'b10;
         src <= s;
         pins <= p;
         wr(4'h8, {24'h0, h, 4'h0}, 2'h0);
         wr(4'h4, {20'h0, c + 3'h3, c + 3'h2, c + 3'h1, c}, 2'h0);
         repeat (8) @(posedge MCLK);
         for (int g = 0; g < 4; g++)
            e[g] = src_of(c + g[2:0], g, s, h, p);
         chk("gen_out", e, GEN_OUT);
      end
   endtask

   // generator mode and override of encoder and trigger sources
   task automatic t_steer();
      src <= 8'h40;
      pins <= 2'b10;
      for (int k = 0; k < 4; k++) begin
         wr(4'h0, {k[1], k[0], 7'h0, k[0] ^ k[1], 22'h0}, 2'h0);
         repeat (8) @(posedge MCLK);
         chk("sync_mode", k[0] ^ k[1], GEN_SYNC_MODE);
         chk("enc_path", k[0], ENC_TO_CIRCUIT);
         chk("trig_path", !k[1], TRIG_TO_CIRCUIT);
      end
   endtask

   task automatic frames(input int n);
      fire <= 1;
      repeat (2 * n) @(posedge MCLK);
      fire <= 0;
      repeat (3) @(posedge MCLK);
   endtask

   // stop count under freeze codes 2, 1 and 0, including a count of zero
   task automatic t_freeze();
      wr(4'h0, 32'h3, 2'h0);
      wr(4'h8, 32'h2, 2'h0);
      frames(4);
      chk("frozen code2", 0, ACQ_FROZEN);
      wr(4'h8, 32'h1, 2'h0);
      frames(2);
      chk("frozen early", 0, ACQ_FROZEN);
      frames(1);
      chk("frozen at n", 1, ACQ_FROZEN);
      rd(4'hc, 32'h80000003, 2'h0);
      wr(4'h8, 32'h0, 2'h0);
      wr(4'h0, 32'h0, 2'h0);
      wr(4'h8, 32'h1, 2'h0);
      repeat (3) @(posedge MCLK);
      chk("frozen zero", 1, ACQ_FROZEN);
      wr(4'h8, 32'h0, 2'h0);
      repeat (2) @(posedge MCLK);
      chk("unfrozen", 0, ACQ_FROZEN);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge MCLK);
      RST_N <= 1;
      repeat (4) @(posedge MCLK);
      t_regs();
      t_mux();
      t_steer();
      t_freeze();
      close_out();
   end

   // hang guard, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge MCLK);
      num_errors++;
      close_out();
   end
endmodule
